// [verilog/eeacc_pkg.sv]
//////////////////////////////////////////////////////////////////////////////
// Purpose: Shared constants and types of the array access unit
// Assumes: Core reaches the unit through I/O space or data space
// Notes:   Offsets are I/O addresses; data space adds a fixed base
//////////////////////////////////////////////////////////////////////////////
`default_nettype none

package eeacc_pkg;

   // I/O addresses of the unit's registers
   localparam logic [5:0]  IO_CTRL         = 6'h1F;
   localparam logic [5:0]  IO_DATA         = 6'h20;
   localparam logic [5:0]  IO_ADDR_LO      = 6'h21;
   localparam logic [5:0]  IO_ADDR_HI      = 6'h22;
   localparam logic [5:0]  IO_BITOP_LAST   = 6'h1F;

   // Window of data space that mirrors the I/O space
   localparam logic [15:0] DS_IO_BASE      = 16'h0020;
   localparam logic [15:0] DS_IO_LAST      = 16'h005F;

   // Control register field positions
   localparam int          BIT_IEN         = 3;
   localparam int          BIT_ARM         = 2;
   localparam int          BIT_WSTB        = 1;
   localparam int          BIT_RSTB        = 0;

   // Cycle counts on the CPU clock
   localparam logic [2:0]  READ_STALL      = 3'h4;
   localparam logic [2:0]  WRITE_STALL     = 3'h2;
   localparam logic [2:0]  ARM_WINDOW      = 3'h4;

   // Write duration in calibrated oscillator cycles
   localparam int          WRITE_OSC_CYCLES = 27072;

   // Address width and array size
   localparam int          ADDR_BITS       = 11;
   localparam int          ARRAY_BYTES     = 2048;

   // Values after reset
   localparam logic [10:0] ADDR_RST        = 11'h000;
   localparam logic [7:0]  DATA_RST        = 8'h00;
   localparam logic [7:0]  RDATA_RST       = 8'h00;

   // One access of the core
   typedef struct packed {
      logic        data_space;
      logic [15:0] addr;
      logic        wr;
      logic        rd;
      logic        bit_set;
      logic        bit_clr;
      logic [2:0]  bit_sel;
      logic [7:0]  wdata;
   } eeacc_req_t;

endpackage

`default_nettype wire

// [verilog/eeacc_wtimer.sv]
//////////////////////////////////////////////////////////////////////////////
// Purpose: Times one array write on the calibrated oscillator
// Assumes: Oscillator arrives as a pin, slower than the CPU clock
// Notes:   Reset only by the power reset, so a system reset cannot abort it
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
`default_nettype none

module eeacc_wtimer #(
   parameter int OSC_CYCLES = eeacc_pkg::WRITE_OSC_CYCLES
) (
   input  wire logic clk_in,
   input  wire logic pwr_arst_n_in,
   input  wire logic osc_in,
   input  wire logic start_in,
   output logic      busy_out,
   output logic      done_out
);

   localparam int            CW   = $clog2(OSC_CYCLES + 1);
   localparam logic [CW-1:0] LAST = CW'(OSC_CYCLES - 1);

   logic          sync1_reg;
   logic          sync2_reg;
   logic          sync3_reg;
   logic          level_reg;
   logic          level_next;
   logic          tick;
   logic [CW-1:0] cnt_reg;

   // Three-stage synchroniser on the oscillator pin
   always_ff @(posedge clk_in or negedge pwr_arst_n_in)
   begin
      if (!pwr_arst_n_in)
      begin
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
         sync3_reg <= 1'b0;
         level_reg <= 1'b0;
      end
      else
      begin
         sync1_reg <= osc_in;
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
         level_reg <= level_next;
      end
   end

   // Level changes only once stages two and three agree
   assign level_next = (sync2_reg == sync3_reg) ? sync3_reg : level_reg;
   assign tick       = level_next & ~level_reg;

   // Write duration counter
   always_ff @(posedge clk_in or negedge pwr_arst_n_in)
   begin
      if (!pwr_arst_n_in)
      begin
         busy_out <= 1'b0;
         done_out <= 1'b0;
         cnt_reg  <= '0;
      end
      else
      begin
         done_out <= 1'b0;
         if (!busy_out)
         begin
            if (start_in)
            begin
               busy_out <= 1'b1;
               cnt_reg  <= '0;
            end
         end
         else if (tick)
         begin
            if (cnt_reg == LAST)
            begin
               busy_out <= 1'b0;
               done_out <= 1'b1;
            end
            else
            begin
               cnt_reg <= cnt_reg + CW'(1);
            end
         end
      end
   end

endmodule

`default_nettype wire

// [verilog/eeacc_unit.sv]
//////////////////////////////////////////////////////////////////////////////
// Purpose: Register-mapped access unit for the on-chip data array
// Assumes: One core access per cycle; core honours stall_out
// Notes:   Write engine sits on the power reset only; the array has no reset
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
`default_nettype none

module eeacc_unit #(
   parameter int ARRAY_BYTES      = eeacc_pkg::ARRAY_BYTES,
   parameter int WRITE_OSC_CYCLES = eeacc_pkg::WRITE_OSC_CYCLES
) (
   input  wire logic                 clk_in,
   input  wire logic                 arst_n_in,
   input  wire logic                 pwr_arst_n_in,
   input  wire eeacc_pkg::eeacc_req_t req_in,
   input  wire logic                 global_ie_in,
   input  wire logic                 sleep_pd_in,
   input  wire logic                 osc_in,
   output logic [7:0]                rdata_out,
   output logic                      rvalid_out,
   output logic                      stall_out,
   output logic                      ready_irq_out,
   output logic                      osc_request_out,
   output logic                      pd_complete_out
);

   localparam int IDX_W = $clog2(ARRAY_BYTES);

   // Decode results
   logic                 io_hit;
   logic [5:0]           io_addr;
   logic                 bitop_ok;
   logic [7:0]           wr_mask;
   logic [7:0]           wr_val;
   logic                 ctrl_wr;
   logic                 data_wr;
   logic                 alo_wr;
   logic                 ahi_wr;

   // Register state
   logic                 ien_reg;
   logic                 arm_reg;
   logic [2:0]           arm_cnt_reg;
   logic [2:0]           stall_cnt_reg;
   logic [10:0]          addr_reg;
   logic [7:0]           data_reg;
   logic [7:0]           rdata_reg;
   logic                 rvalid_reg;

   // Write engine state
   logic [IDX_W-1:0]     lat_idx_reg;
   logic [7:0]           lat_data_reg;
   logic                 osc_hold_reg;
   logic                 busy;
   logic                 done;
   logic                 launch;
   logic                 read_go;
   logic [IDX_W-1:0]     rd_idx;
   logic [7:0]           mem [ARRAY_BYTES];

   ///////////////////////////////////////////////////////////////////////////
   // Address decode
   ///////////////////////////////////////////////////////////////////////////

   // Map I/O or data space access onto an I/O address
   always_comb
   begin
      io_hit  = 1'b0;
      io_addr = 6'h00;
      if (!req_in.data_space)
      begin
         io_hit  = 1'b1;
         io_addr = req_in.addr[5:0];
      end
      else if (req_in.addr >= eeacc_pkg::DS_IO_BASE && req_in.addr <= eeacc_pkg::DS_IO_LAST)
      begin
         io_hit  = 1'b1;
         io_addr = 6'(req_in.addr - eeacc_pkg::DS_IO_BASE);
      end
   end

   // Single-bit ops only in the low I/O range
   assign bitop_ok = io_hit & ~req_in.data_space & (io_addr <= eeacc_pkg::IO_BITOP_LAST)
                     & (req_in.bit_set | req_in.bit_clr);

   // Per-bit write mask and value
   always_comb
   begin
      wr_mask = 8'h00;
      wr_val  = 8'h00;
      if (bitop_ok)
      begin
         wr_mask = 8'h01 << req_in.bit_sel;
         wr_val  = req_in.bit_set ? wr_mask : 8'h00;
      end
      else if (io_hit && req_in.wr)
      begin
         wr_mask = 8'hFF;
         wr_val  = req_in.wdata;
      end
   end

   // Register select strobes
   assign ctrl_wr = (wr_mask != 8'h00) && (io_addr == eeacc_pkg::IO_CTRL);
   assign data_wr = (wr_mask == 8'hFF) && (io_addr == eeacc_pkg::IO_DATA);
   assign alo_wr  = (wr_mask == 8'hFF) && (io_addr == eeacc_pkg::IO_ADDR_LO);
   assign ahi_wr  = (wr_mask == 8'hFF) && (io_addr == eeacc_pkg::IO_ADDR_HI);

   ///////////////////////////////////////////////////////////////////////////
   // Control register
   ///////////////////////////////////////////////////////////////////////////

   // Launch and read triggers
   assign launch  = ctrl_wr & wr_mask[eeacc_pkg::BIT_WSTB] & wr_val[eeacc_pkg::BIT_WSTB]
                    & arm_reg & ~busy;
   assign read_go = ctrl_wr & wr_mask[eeacc_pkg::BIT_RSTB] & wr_val[eeacc_pkg::BIT_RSTB]
                    & ~busy;

   // Ready interrupt enable
   always_ff @(posedge clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         ien_reg <= 1'b0;
      end
      else if (ctrl_wr && wr_mask[eeacc_pkg::BIT_IEN])
      begin
         ien_reg <= wr_val[eeacc_pkg::BIT_IEN];
      end
   end

   // Arm bit with its self-clearing window
   always_ff @(posedge clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         arm_reg     <= 1'b0;
         arm_cnt_reg <= 3'h0;
      end
      else if (ctrl_wr && wr_mask[eeacc_pkg::BIT_ARM] && wr_val[eeacc_pkg::BIT_ARM])
      begin
         arm_reg     <= 1'b1;
         arm_cnt_reg <= eeacc_pkg::ARM_WINDOW;
      end
      else if (arm_reg)
      begin
         arm_cnt_reg <= arm_cnt_reg - 3'h1;
         if (arm_cnt_reg == 3'h1)
         begin
            arm_reg <= 1'b0;
         end
      end
   end

   // Core stall after a read or a launched write
   always_ff @(posedge clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         stall_cnt_reg <= 3'h0;
      end
      else if (read_go)
      begin
         stall_cnt_reg <= eeacc_pkg::READ_STALL;
      end
      else if (launch)
      begin
         stall_cnt_reg <= eeacc_pkg::WRITE_STALL;
      end
      else if (stall_cnt_reg != 3'h0)
      begin
         stall_cnt_reg <= stall_cnt_reg - 3'h1;
      end
   end

   assign stall_out = (stall_cnt_reg != 3'h0);

   ///////////////////////////////////////////////////////////////////////////
   // Address and data registers
   ///////////////////////////////////////////////////////////////////////////

   // Address pair, frozen while a write runs
   always_ff @(posedge clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         addr_reg <= eeacc_pkg::ADDR_RST;
      end
      else if (!busy)
      begin
         if (alo_wr)
         begin
            addr_reg[7:0] <= wr_val;
         end
         if (ahi_wr)
         begin
            addr_reg[10:8] <= wr_val[2:0];
         end
      end
   end

   // Index into the array; top bit drops out on the small variant
   assign rd_idx = addr_reg[IDX_W-1:0];

   // Data register, loaded at once by a read strobe
   always_ff @(posedge clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         data_reg <= eeacc_pkg::DATA_RST;
      end
      else if (read_go)
      begin
         data_reg <= mem[rd_idx];
      end
      else if (data_wr)
      begin
         data_reg <= wr_val;
      end
   end

   ///////////////////////////////////////////////////////////////////////////
   // Write engine, immune to system reset
   ///////////////////////////////////////////////////////////////////////////

   // Capture target and byte at launch
   always_ff @(posedge clk_in or negedge pwr_arst_n_in)
   begin
      if (!pwr_arst_n_in)
      begin
         lat_idx_reg  <= '0;
         lat_data_reg <= 8'h00;
      end
      else if (launch)
      begin
         lat_idx_reg  <= rd_idx;
         lat_data_reg <= data_reg;
      end
   end

   // Duration timer on the calibrated oscillator
   eeacc_wtimer #(
      .OSC_CYCLES (WRITE_OSC_CYCLES)
   ) u_wtimer (
      .clk_in        (clk_in),
      .pwr_arst_n_in (pwr_arst_n_in),
      .osc_in        (osc_in),
      .start_in      (launch),
      .busy_out      (busy),
      .done_out      (done)
   );

   // Array commit when the write time is over
   always_ff @(posedge clk_in)
   begin
      if (done)
      begin
         mem[lat_idx_reg] <= lat_data_reg;
      end
   end

   // Oscillator kept on past a write that ran into power-down
   always_ff @(posedge clk_in or negedge pwr_arst_n_in)
   begin
      if (!pwr_arst_n_in)
      begin
         osc_hold_reg <= 1'b0;
      end
      else if (done && sleep_pd_in)
      begin
         osc_hold_reg <= 1'b1;
      end
      else if (!sleep_pd_in)
      begin
         osc_hold_reg <= 1'b0;
      end
   end

   // Sleep has no effect on a running write; the done cycle bridges to the hold
   assign osc_request_out = busy | (done & sleep_pd_in) | osc_hold_reg;
   assign pd_complete_out = sleep_pd_in & ~osc_request_out;

   ///////////////////////////////////////////////////////////////////////////
   // Read-back and interrupt
   ///////////////////////////////////////////////////////////////////////////

   // Registered read data, one cycle after the request
   always_ff @(posedge clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         rdata_reg  <= eeacc_pkg::RDATA_RST;
         rvalid_reg <= 1'b0;
      end
      else
      begin
         rvalid_reg <= io_hit & req_in.rd;
         if (io_hit && req_in.rd)
         begin
            case (io_addr)
               eeacc_pkg::IO_CTRL:    rdata_reg <= {4'h0, ien_reg, arm_reg, busy, 1'b0};
               eeacc_pkg::IO_DATA:    rdata_reg <= data_reg;
               eeacc_pkg::IO_ADDR_LO: rdata_reg <= addr_reg[7:0];
               eeacc_pkg::IO_ADDR_HI: rdata_reg <= {5'h00, addr_reg[10:8]};
               default:               rdata_reg <= 8'h00;
            endcase
         end
      end
   end

   assign rdata_out  = rdata_reg;
   assign rvalid_out = rvalid_reg;

   // Level interrupt while no write is running
   assign ready_irq_out = ien_reg & global_ie_in & ~busy;

endmodule

`default_nettype wire

// [tb/eeacc_unit_props.sv]
// Purpose: Port-level checks of the array access unit
// Assumes: Core obeys stall_out; write strobes only while idle
// Notes:   Write busy shows as osc_request_out while sleep is low
`timescale 1ns/1ps
`default_nettype none

module eeacc_unit_props (
   input  wire logic                  clk_in,
   input  wire logic                  arst_n_in,
   input  wire eeacc_pkg::eeacc_req_t req_in,
   input  wire logic                  global_ie_in,
   input  wire logic                  sleep_pd_in,
   input  wire logic [7:0]            rdata_out,
   input  wire logic                  rvalid_out,
   input  wire logic                  stall_out,
   input  wire logic                  ready_irq_out,
   input  wire logic                  osc_request_out,
   input  wire logic                  pd_complete_out
);
   logic       ctrl_hit;
   logic [7:0] ctrl_set;
   logic       busy;
   logic [2:0] arm_cnt;
   logic       sleep_reg;

   // Bits set in the control register by a full write or a bit set
   assign ctrl_hit = !req_in.data_space && req_in.addr[5:0] == eeacc_pkg::IO_CTRL;
   assign ctrl_set = !ctrl_hit ? 8'h00 : req_in.bit_set ? (8'h01 << req_in.bit_sel) :
                     (req_in.wr && !req_in.bit_clr) ? req_in.wdata : 8'h00;
   assign busy     = osc_request_out && !sleep_pd_in && !sleep_reg;

   // Shadow of the arm window
   always_ff @(posedge clk_in or negedge arst_n_in)
      if (!arst_n_in)
         arm_cnt <= 3'h0;
      else if (ctrl_set[2])
         arm_cnt <= eeacc_pkg::ARM_WINDOW;
      else if (arm_cnt != 3'h0)
         arm_cnt <= arm_cnt - 3'h1;

   // Sleep one cycle back, masks the hold that lingers after wake
   always_ff @(posedge clk_in or negedge arst_n_in)
      if (!arst_n_in)
         sleep_reg <= 1'b0;
      else
         sleep_reg <= sleep_pd_in;

   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!arst_n_in);

   sequence s_read_halt;
      stall_out [*4];
   endsequence
   sequence s_write_halt;
      stall_out [*2] ##1 !stall_out;
   endsequence

   a_read_stall: assert property (ctrl_set[0] && !osc_request_out && !stall_out |=> s_read_halt)
      else $error("read strobe stall wrong");
   a_write_stall: assert property (ctrl_set[1] && arm_cnt != 3'h0 && !osc_request_out |=> s_write_halt)
      else $error("write launch stall wrong");
   a_write_start: assert property (ctrl_set[1] && arm_cnt != 3'h0 && !osc_request_out |=> busy && !ready_irq_out)
      else $error("armed strobe did not launch");
   a_arm_expired: assert property (ctrl_set[1] && arm_cnt == 3'h0 && !osc_request_out |=> !osc_request_out && !stall_out)
      else $error("unarmed strobe launched");
   a_busy_refuse: assert property (ctrl_set[0] && busy && !stall_out |=> !stall_out)
      else $error("read accepted while busy");
   a_irq_gate: assert property (ready_irq_out |-> global_ie_in && !busy)
      else $error("ready interrupt without cause");
   a_read_answer: assert property (req_in.rd && !req_in.data_space |=> rvalid_out)
      else $error("read not answered");
   a_ctrl_resv: assert property (req_in.rd && ctrl_hit |=> rdata_out[7:4] == 4'h0 && !rdata_out[0])
      else $error("control reserved bits set");
   a_pd_hold: assert property (sleep_pd_in && osc_request_out |=> !sleep_pd_in || (osc_request_out && !pd_complete_out))
      else $error("oscillator dropped during power-down");
endmodule

bind eeacc_unit eeacc_unit_props i_props (
   .clk_in(clk_in), .arst_n_in(arst_n_in), .req_in(req_in), .global_ie_in(global_ie_in),
   .sleep_pd_in(sleep_pd_in), .rdata_out(rdata_out), .rvalid_out(rvalid_out), .stall_out(stall_out),
   .ready_irq_out(ready_irq_out), .osc_request_out(osc_request_out), .pd_complete_out(pd_complete_out)
);
`default_nettype wire

// [tb/eeacc_core_model.sv]
// Purpose: Core model issuing one register access at a time
// Assumes: Called one time unit after a rising clock edge
// Notes:   Waits out every stall before the next access
`timescale 1ns/1ps
`default_nettype none

module eeacc_core_model (
   input  wire logic             clk_in,
   input  wire logic             stall_in,
   output eeacc_pkg::eeacc_req_t req_out
);
   // Idle bus at time zero
   initial req_out = '0;

   // One access held over one edge; op is wr, rd, bit set, bit clear
   task automatic access(input logic ds, input logic [15:0] a, input logic [3:0] op,
                         input logic [2:0] sel, input logic [7:0] d);
      req_out = {ds, a, op, sel, d};
      @(posedge clk_in);
      #1;
      req_out = '0;
      // One idle edge so two accesses never meet in one time step
      @(posedge clk_in);
      #1;
      // Next access right after the stall ends
      while (stall_in === 1'b1)
      begin
         @(posedge clk_in);
         #1;
      end
   endtask
endmodule
`default_nettype wire

// [tb/eeacc_unit_tb_top.sv]
// Purpose: Self-checking bench of the array access unit
// Assumes: Short write time set by parameter
// Notes:   Reads queue their expected byte; a monitor compares
`timescale 1ns/1ps
`default_nettype none

module eeacc_unit_tb_top;
   localparam int         OSC_N = 8;
   logic                  clk_in = 1'b0;
   logic                  arst_n_in = 1'b0;
   logic                  pwr_n = 1'b0;
   logic                  global_ie_in = 1'b0;
   logic                  sleep_pd_in = 1'b0;
   logic                  osc_in = 1'b0;
   eeacc_pkg::eeacc_req_t req;
   logic [7:0]            rdata;
   logic                  rvalid, stall, irq, oscreq, pdc;
   logic [7:0]            exp_q[$];
   int                    miscompares = 0;
   int                    check_count = 0;
   int                    seed = 42464;
   logic [10:0]           addr_v;
   logic [7:0]            data_v;

   // CPU clock and free running oscillator
   always #2.5 clk_in = ~clk_in;
   always #18.5 osc_in = ~osc_in;

   eeacc_unit #(.ARRAY_BYTES(2048), .WRITE_OSC_CYCLES(OSC_N)) i_eeacc_unit (
      .clk_in(clk_in), .arst_n_in(arst_n_in), .pwr_arst_n_in(pwr_n), .req_in(req),
      .global_ie_in(global_ie_in), .sleep_pd_in(sleep_pd_in), .osc_in(osc_in), .rdata_out(rdata),
      .rvalid_out(rvalid), .stall_out(stall), .ready_irq_out(irq), .osc_request_out(oscreq),
      .pd_complete_out(pdc));
   eeacc_core_model i_eeacc_core_model (.clk_in(clk_in), .stall_in(stall), .req_out(req));

   task automatic check(input logic [7:0] seen, input logic [7:0] want);
      check_count++;
      if (seen !== want)
      begin
         miscompares++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // Register accesses through the core model
   task automatic wr(input logic [5:0] r, input logic [7:0] d);
      i_eeacc_core_model.access(1'b0, {10'h000, r}, 4'h8, 3'h0, d);
   endtask
   task automatic rd(input logic [5:0] r, input logic [7:0] want);
      exp_q.push_back(want);
      i_eeacc_core_model.access(1'b0, {10'h000, r}, 4'h4, 3'h0, 8'h00);
   endtask
   task automatic bset(input logic [2:0] s);
      i_eeacc_core_model.access(1'b0, {10'h000, eeacc_pkg::IO_CTRL}, 4'h2, s, 8'h00);
   endtask
   task automatic set_addr(input logic [10:0] x, input logic ds);
      i_eeacc_core_model.access(ds, ds ? 16'h0041 : 16'h0021, 4'h8, 3'h0, x[7:0]);
      i_eeacc_core_model.access(ds, ds ? 16'h0042 : 16'h0022, 4'h8, 3'h0, {5'h00, x[10:8]});
   endtask
   task automatic launch(input logic [10:0] x, input logic [7:0] d, input logic ds);
      set_addr(x, ds);
      wr(eeacc_pkg::IO_DATA, d);
      bset(3'h2);
      bset(3'h1);
   endtask
   task automatic readback(input logic [10:0] x, input logic [7:0] d);
      set_addr(x, 1'b0);
      wr(eeacc_pkg::IO_CTRL, 8'h09);
      rd(eeacc_pkg::IO_DATA, d);
   endtask
   task automatic wait_done();
      int n = 0;
      while (oscreq !== 1'b0 && n < 400)
      begin
         @(posedge clk_in);
         #1;
         n++;
      end
      check({7'h00, oscreq}, 8'h00);
   endtask

   // Compare each read answer with the oldest note
   always @(posedge clk_in)
      if (rvalid === 1'b1)
         check(rdata, exp_q.size() != 0 ? exp_q.pop_front() : 8'hXX);

   // Main sequence
   initial
   begin
      repeat (10) @(posedge clk_in);
      #1;
      arst_n_in = 1'b1;
      pwr_n = 1'b1;
      rd(eeacc_pkg::IO_CTRL, 8'h00);
      rd(6'h30, 8'h00);
      wr(eeacc_pkg::IO_ADDR_HI, 8'hFF);
      rd(eeacc_pkg::IO_ADDR_HI, 8'h07);
      wr(eeacc_pkg::IO_CTRL, 8'hF8);
      rd(eeacc_pkg::IO_CTRL, 8'h08);
      check({7'h00, irq}, 8'h00);
      global_ie_in = 1'b1;
      @(posedge clk_in);
      #1;
      check({7'h00, irq}, 8'h01);
      // Random bytes at random places, both address spaces
      for (int i = 0; i < 3; i++)
      begin
         addr_v = 11'($random(seed));
         data_v = 8'($random(seed));
         launch(addr_v, data_v, i[0]);
         check({7'h00, irq}, 8'h00);
         wr(eeacc_pkg::IO_ADDR_LO, ~addr_v[7:0]);
         rd(eeacc_pkg::IO_CTRL, 8'h0A);
         bset(3'h0);
         wait_done();
         check({7'h00, irq}, 8'h01);
         rd(eeacc_pkg::IO_ADDR_LO, addr_v[7:0]);
         readback(addr_v, data_v);
      end
      // Strobe on the last cycle of the arm window, then one late
      for (int gap = 2; gap < 4; gap++)
      begin
         wr(eeacc_pkg::IO_CTRL, 8'h0C);
         repeat (gap) @(posedge clk_in);
         #1;
         wr(eeacc_pkg::IO_CTRL, 8'h0A);
         check({7'h00, oscreq}, {7'h00, gap == 2});
         wait_done();
      end
      // Power-down entered during a write
      launch(11'h7FF, 8'hA5, 1'b0);
      sleep_pd_in = 1'b1;
      repeat (300) @(posedge clk_in);
      #1;
      check({6'h00, oscreq, pdc}, 8'h02);
      sleep_pd_in = 1'b0;
      wait_done();
      readback(11'h7FF, 8'hA5);
      // System reset during a write
      launch(11'h400, 8'h3C, 1'b1);
      arst_n_in = 1'b0;
      repeat (2) @(posedge clk_in);
      #1;
      arst_n_in = 1'b1;
      check({7'h00, oscreq}, 8'h01);
      rd(eeacc_pkg::IO_CTRL, 8'h02);
      wait_done();
      readback(11'h400, 8'h3C);
      // Bit clear drops only the enable; a bit set above 0x1F is ignored
      i_eeacc_core_model.access(1'b0, {10'h000, eeacc_pkg::IO_CTRL}, 4'h1, 3'h3, 8'h00);
      check({7'h00, irq}, 8'h00);
      rd(eeacc_pkg::IO_CTRL, 8'h00);
      i_eeacc_core_model.access(1'b0, {10'h000, eeacc_pkg::IO_DATA}, 4'h2, 3'h7, 8'h00);
      rd(eeacc_pkg::IO_DATA, 8'h3C);
      repeat (3) @(posedge clk_in);
      give_verdict();
   end

   // Cut a hang short
   initial
   begin
      #40000;
      miscompares++;
      give_verdict();
   end
endmodule
`default_nettype wire
